//--- rtl/pin_change_defs.svh
// Register offsets, field positions, reset values and timing counts of the pin change detector
`ifndef PIN_CHANGE_DEFS_SVH
`define PIN_CHANGE_DEFS_SVH

`define PC_ADDR_W          4
`define PC_DATA_W          8
`define PC_PIN_COUNT       8
`define PC_OFF_RISE_EN     4'h0
`define PC_OFF_FALL_EN     4'h1
`define PC_OFF_FLAGS       4'h2
`define PC_OFF_CONTROL     4'h3
`define PC_OFF_IRQ_STATUS  4'h4
`define PC_OFF_IRQ_MASK    4'h5
`define PC_OFF_PIN_LEVEL   4'h6
`define PC_CTRL_MASTER_BIT 0
`define PC_CTRL_SLEEP_BIT  1
`define PC_STAT_CHANGE_BIT 0
`define PC_STAT_WAKE_BIT   1
`define PC_RESET_BYTE      8'h00
`define PC_UNMAPPED_READ   8'h00
`define PC_SYNC_STAGES     3

`endif

//--- rtl/pin_change_pkg.sv
// Types shared by the pin change detector files
package pin_change_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef enum logic [0:0] {
        ST_RUN   = 1'b0,
        ST_SLEEP = 1'b1
    } power_state_t;

endpackage : pin_change_pkg

//--- rtl/pin_edge_change_interrupt.sv
// Edge change detector and interrupt for an eight-pin input port
//
// Operation
// - Separate rise and fall detector per pin
// - Rise detection gated by rise enable bit
// - Fall detection gated by fall enable bit
// - Both bits set detects either edge
// - Enable bit n controls pin n
// - Enabled edge sets sticky pin flag
// - Detection continues with master enable cleared
// - Summary flag ORs flags; master gates the flag irq, not the masked status irq
// - Writing zero clears a pin flag
// - Edge during clear keeps flag set
// - Enabled edge wakes sleep if master set
// - Flag recorded on the same edge that wake is signalled
//
// The implementer's own choices: the register offsets and strobed register access.
`include "pin_change_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module pin_edge_change_interrupt
    import pin_change_pkg::*;
#(
    parameter int PINS = `PC_PIN_COUNT
) (
    // Clock and reset
    input  wire logic            core_clk_i,
    input  wire logic            rst_i,
    // Register port
    input  wire logic [3:0]      addr_i,
    input  wire logic [7:0]      wdata_i,
    input  wire logic            wr_i,
    input  wire logic            rd_i,
    output logic      [7:0]      rdata_o,
    // Port pins
    input  wire logic [PINS-1:0] input_port_i,
    // Core side
    output logic                 change_summary_flag_o,
    output logic                 irq_o,
    output logic                 wake_o
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    reg_req_t         req;
    logic [PINS-1:0]  rise_edge_enable;
    logic [PINS-1:0]  fall_edge_enable;
    logic [PINS-1:0]  change_flags;
    logic             change_irq_master_enable;
    power_state_t     power_state;
    logic [1:0]       irq_status;
    logic [1:0]       irq_mask;
    logic [PINS-1:0]  pin_level;
    logic [PINS-1:0]  pin_prev;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire wr_rise   = req.wr && (req.addr == `PC_OFF_RISE_EN);
    wire wr_fall   = req.wr && (req.addr == `PC_OFF_FALL_EN);
    wire wr_flags  = req.wr && (req.addr == `PC_OFF_FLAGS);
    wire wr_ctrl   = req.wr && (req.addr == `PC_OFF_CONTROL);
    wire wr_status = req.wr && (req.addr == `PC_OFF_IRQ_STATUS);
    wire wr_mask   = req.wr && (req.addr == `PC_OFF_IRQ_MASK);

    // ------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------
    pin_sync #(
        .WIDTH (PINS)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .pin_i      (input_port_i),
        .level_o    (pin_level)
    );

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_prev <= `PC_RESET_BYTE;
        end else begin
            pin_prev <= pin_level;
        end
    end

    logic [PINS-1:0] rise_seen;
    logic [PINS-1:0] fall_seen;
    logic [PINS-1:0] edge_hit;
    logic [PINS-1:0] next_flags;

    // One rise and one fall detector per pin, bit n on pin n
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            assign rise_seen[g] = pin_level[g] & ~pin_prev[g] & rise_edge_enable[g];
            assign fall_seen[g] = ~pin_level[g] & pin_prev[g] & fall_edge_enable[g];
            assign edge_hit[g]  = rise_seen[g] | fall_seen[g];
            // A write keeps only the ones written; a new edge wins over the clear
            assign next_flags[g] = edge_hit[g] | (change_flags[g] & (~wr_flags | req.wdata[g]));
        end
    endgenerate

    wire any_edge    = |edge_hit;
    wire summary_now = |next_flags;
    wire wake_event  = (power_state == ST_SLEEP) && any_edge && change_irq_master_enable;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rise_edge_enable         <= `PC_RESET_BYTE;
            fall_edge_enable         <= `PC_RESET_BYTE;
            change_irq_master_enable <= 1'b0;
            irq_mask                 <= 2'h0;
        end else begin
            if (wr_rise) begin
                rise_edge_enable <= req.wdata;
            end
            if (wr_fall) begin
                fall_edge_enable <= req.wdata;
            end
            if (wr_ctrl) begin
                change_irq_master_enable <= req.wdata[`PC_CTRL_MASTER_BIT];
            end
            if (wr_mask) begin
                irq_mask <= req.wdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Flags, sleep and wake
    // ------------------------------------------------------------
    // Flags update whatever the master enable says
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            change_flags <= `PC_RESET_BYTE;
        end else begin
            change_flags <= next_flags;
        end
    end

    // Sleep is entered by software; a wake edge ends it
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            power_state <= ST_RUN;
            wake_o      <= 1'b0;
        end else begin
            wake_o <= wake_event;
            unique case (power_state)
                ST_RUN: begin
                    if (wr_ctrl && req.wdata[`PC_CTRL_SLEEP_BIT]) begin
                        power_state <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (wake_event) begin
                        power_state <= ST_RUN;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, set wins over write-one clear
    // ------------------------------------------------------------
    logic [1:0] status_set;
    assign status_set[`PC_STAT_CHANGE_BIT] = any_edge;
    assign status_set[`PC_STAT_WAKE_BIT]   = wake_event;
    wire [1:0] next_status = status_set | (irq_status & ~(wr_status ? req.wdata[1:0] : 2'h0));
    wire       flag_irq    = summary_now & change_irq_master_enable;
    wire       status_irq  = |(next_status & irq_mask);

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_status            <= 2'h0;
            change_summary_flag_o <= 1'b0;
            irq_o                 <= 1'b0;
        end else begin
            irq_status            <= next_status;
            change_summary_flag_o <= summary_now;
            // The master enable gates the pin-flag path; status bits add their own
            irq_o <= flag_irq | status_irq;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [7:0] read_mux;
    always_comb begin
        read_mux = `PC_UNMAPPED_READ;
        unique case (req.addr)
            `PC_OFF_RISE_EN:    read_mux = rise_edge_enable;
            `PC_OFF_FALL_EN:    read_mux = fall_edge_enable;
            `PC_OFF_FLAGS:      read_mux = change_flags;
            `PC_OFF_CONTROL:    read_mux = {6'h00, power_state == ST_SLEEP, change_irq_master_enable};
            `PC_OFF_IRQ_STATUS: read_mux = {6'h00, irq_status};
            `PC_OFF_IRQ_MASK:   read_mux = {6'h00, irq_mask};
            `PC_OFF_PIN_LEVEL:  read_mux = pin_level;
            default:            read_mux = `PC_UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= req.rd ? read_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_rise_sets_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (pin_level[0] && !pin_prev[0] && rise_edge_enable[0]) |=> change_flags[0])
        else $error("rise edge did not set flag");
    a_fall_sets_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!pin_level[1] && pin_prev[1] && fall_edge_enable[1]) |=> change_flags[1])
        else $error("fall edge did not set flag");
    a_disabled_no_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!change_flags[2] && rise_edge_enable[2] == 1'b0 && fall_edge_enable[2] == 1'b0) |=> !change_flags[2])
        else $error("flag set with detectors off");
    a_flag_sticky: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (change_flags[3] && !wr_flags) |=> change_flags[3])
        else $error("flag dropped without write");
    a_zero_clears: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (wr_flags && !req.wdata[4] && !edge_hit[4]) |=> !change_flags[4])
        else $error("write zero did not clear");
    a_edge_beats_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (wr_flags && edge_hit[5]) |=> change_flags[5])
        else $error("clear beat new edge");
    a_summary_or: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ##1 change_summary_flag_o == (|change_flags))
        else $error("summary flag not OR of flags");
    a_irq_gated: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!change_irq_master_enable && irq_mask == 2'h0) |=> !irq_o)
        else $error("irq raised with master off");
    a_wake_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
        wake_o |-> (|change_flags) && power_state == ST_RUN)
        else $error("wake before flag recorded");
    a_sleep_wake: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (power_state == ST_SLEEP && any_edge && change_irq_master_enable) |=> wake_o ##1 !wake_o)
        else $error("no wake from sleep");

    // ------------------------------------------------------------
    // Per-pin checks, every pin watched alike
    // ------------------------------------------------------------
    generate
        for (g = 0; g < PINS; g++) begin : g_pin_chk
            a_pin_rise: assert property (@(posedge core_clk_i) disable iff (rst_i)
                (pin_level[g] && !pin_prev[g] && rise_edge_enable[g]) |=> change_flags[g])
                else $error("rise edge did not set its pin flag");
            a_pin_fall: assert property (@(posedge core_clk_i) disable iff (rst_i)
                (!pin_level[g] && pin_prev[g] && fall_edge_enable[g]) |=> change_flags[g])
                else $error("fall edge did not set its pin flag");
            a_rise_gated: assert property (@(posedge core_clk_i) disable iff (rst_i)
                (pin_level[g] && !pin_prev[g] && !rise_edge_enable[g] && !change_flags[g]) |=> !change_flags[g])
                else $error("disabled rise edge set a flag");
            a_fall_gated: assert property (@(posedge core_clk_i) disable iff (rst_i)
                (!pin_level[g] && pin_prev[g] && !fall_edge_enable[g] && !change_flags[g]) |=> !change_flags[g])
                else $error("disabled fall edge set a flag");
            a_either_edge: assert property (@(posedge core_clk_i) disable iff (rst_i)
                (rise_edge_enable[g] && fall_edge_enable[g] && pin_level[g] != pin_prev[g]) |=> change_flags[g])
                else $error("edge missed with both detectors on");
            a_pin_sticky: assert property (@(posedge core_clk_i) disable iff (rst_i)
                (change_flags[g] && !wr_flags) |=> change_flags[g])
                else $error("pin flag dropped without a write");
            a_pin_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i)
                (!change_flags[g] && pin_level[g] == pin_prev[g]) |=> !change_flags[g])
                else $error("pin flag set without an edge");
            a_pin_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
                (wr_flags && !req.wdata[g] && pin_level[g] == pin_prev[g]) |=> !change_flags[g])
                else $error("written zero left a pin flag set");
            a_fall_wins: assert property (@(posedge core_clk_i) disable iff (rst_i)
                (wr_flags && !pin_level[g] && pin_prev[g] && fall_edge_enable[g]) |=> change_flags[g])
                else $error("clear beat a fall edge");
            a_master_free: assert property (@(posedge core_clk_i) disable iff (rst_i)
                (!change_irq_master_enable && edge_hit[g]) |=> change_flags[g])
                else $error("detection stopped with master off");
            a_flag_summary: assert property (@(posedge core_clk_i) disable iff (rst_i)
                change_flags[g] |-> change_summary_flag_o)
                else $error("summary flag low with a pin flag set");
        end
    endgenerate

    // ------------------------------------------------------------
    // Register, interrupt, wake and reset checks
    // ------------------------------------------------------------
    a_prev_tracks: assert property (@(posedge core_clk_i) disable iff (rst_i)
        1'b1 |=> pin_prev == $past(pin_level))
        else $error("previous level not one cycle old");
    a_irq_follows: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ($past(change_irq_master_enable) && change_summary_flag_o) |-> irq_o)
        else $error("irq low with flags and master set");
    a_irq_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!$past(change_irq_master_enable) && !(|(irq_status & $past(irq_mask)))) |-> !irq_o)
        else $error("irq high with no enabled source");
    a_wake_master: assert property (@(posedge core_clk_i) disable iff (rst_i)
        wake_o |-> $past(change_irq_master_enable))
        else $error("wake with master off");
    a_wake_asleep: assert property (@(posedge core_clk_i) disable iff (rst_i)
        wake_o |-> $past(power_state) == ST_SLEEP)
        else $error("wake while running");
    a_wake_pulse: assert property (@(posedge core_clk_i) disable iff (rst_i)
        wake_o |=> !wake_o)
        else $error("wake longer than one cycle");
    a_sleep_entry: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (power_state == ST_RUN && wr_ctrl && req.wdata[`PC_CTRL_SLEEP_BIT]) |=> power_state == ST_SLEEP)
        else $error("sleep request not taken");
    a_status_w1c: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (wr_status && req.wdata[`PC_STAT_WAKE_BIT] && !wake_event) |=> !irq_status[`PC_STAT_WAKE_BIT])
        else $error("wake status not cleared");
    a_flag_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (req.rd && req.addr == `PC_OFF_FLAGS) |=> rdata_o == $past(change_flags))
        else $error("flag read returned wrong data");
    a_level_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (req.rd && req.addr == `PC_OFF_PIN_LEVEL) |=> rdata_o == $past(pin_level))
        else $error("level read returned wrong data");
    a_status_edge: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (|edge_hit) |=> irq_status[`PC_STAT_CHANGE_BIT])
        else $error("edge did not set change status");
    a_summary_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !(|change_flags) |-> !change_summary_flag_o)
        else $error("summary flag high with no flags");
    a_rise_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        wr_rise |=> rise_edge_enable == $past(req.wdata))
        else $error("rise enable write lost");
    a_fall_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        wr_fall |=> fall_edge_enable == $past(req.wdata))
        else $error("fall enable write lost");
    a_reset_clean: assert property (@(posedge core_clk_i)
        rst_i |=> (change_flags == '0 && !irq_o && !wake_o && !change_summary_flag_o && rdata_o == 8'h00))
        else $error("state not cleared by reset");

endmodule : pin_edge_change_interrupt

`default_nettype wire

//--- rtl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rst_i,
    // Pins and filtered level
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // Stage one feeds stage two only; level moves once two and three agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge core_clk_i) begin
                if (rst_i) begin
                    stage1[g]  <= 1'b0;
                    stage2[g]  <= 1'b0;
                    stage3[g]  <= 1'b0;
                    level_o[g] <= 1'b0;
                end else begin
                    stage1[g] <= pin_i[g];
                    stage2[g] <= stage1[g];
                    stage3[g] <= stage2[g];
                    if (stage2[g] == stage3[g]) begin
                        level_o[g] <= stage3[g];
                    end
                end
            end
        end
    endgenerate

endmodule : pin_sync

`default_nettype wire

//--- test/pin_edge_change_interrupt_tb_top.sv
// Self-checking bench of the pin edge change detector
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end

module pin_edge_change_interrupt_tb_top;
    import pin_change_pkg::*;

    logic       core_clk, rst, wr, rd, summary, irq, wake, master, seen;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, pins, want, v, re, fe, old, exp_f, m;
    int         n_mismatch, samples_checked, cycles;

    pin_source ps (.core_clk_i(core_clk), .want_i(want), .pins_o(pins));
    pin_edge_change_interrupt uut (.core_clk_i(core_clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .input_port_i(pins), .change_summary_flag_o(summary),
        .irq_o(irq), .wake_o(wake));

    // --------------------------------------------
    // Bus tasks and expectation
    // --------------------------------------------
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        @(negedge core_clk);
        d = rdata;
    endtask : rd_reg

    task automatic set_pins(input logic [7:0] p, input int n);
        @(posedge core_clk);
        want <= p;
        repeat (n) @(posedge core_clk);
    endtask : set_pins

    function automatic logic [7:0] next_flags(logic [7:0] f, r, fl, o, n);
        return f | (r & ~o & n) | (fl & o & ~n);
    endfunction : next_flags

    task automatic print_verdict();
        if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Hang guard well above the expected run length
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    initial begin
        rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 8'h00; want = 8'h00;
        void'($urandom(32'h04b8));
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd_reg(i == 3 ? 4'hf : 4'(i), v);
            `CHK(v, 8'h00)
        end
        // Write landing before, with and after the edge
        wr_reg(4'h0, 8'h01);
        for (int j = 1; j <= 8; j++) begin
            wr_reg(4'h2, 8'h00);
            set_pins(8'h01, j - 1);
            wr_reg(4'h2, 8'h00);
            repeat (6) @(posedge core_clk);
            rd_reg(4'h2, v);
            `CHK(v, {7'h00, j <= 5})
            set_pins(8'h00, 8);
        end
        wr_reg(4'h2, 8'h00);
        exp_f = 8'h00;
        for (int k = 0; k < 40; k++) begin
            re     = 8'($urandom);
            fe     = 8'($urandom);
            master = 1'($urandom);
            old    = want;
            if (k < 2) begin re = k ? 8'h00 : 8'hff; fe = k ? 8'hff : 8'h00; end
            wr_reg(4'h0, re);
            wr_reg(4'h1, fe);
            wr_reg(4'h3, {7'h00, master});
            set_pins(k < 2 ? ~old : 8'($urandom), 12);
            exp_f = next_flags(exp_f, re, fe, old, want);
            rd_reg(4'h2, v);
            `CHK(v, exp_f)
            `CHK(summary, |exp_f)
            `CHK(irq, (|exp_f) & master)
            rd_reg(4'h6, v);
            `CHK(v, want)
            rd_reg(4'h3, v);
            `CHK(v, {7'h00, master})
            // Clear only bits already seen set, so later edges survive
            m = ~(exp_f & 8'($urandom));
            wr_reg(4'h2, m);
            exp_f = exp_f & m;
            rd_reg(4'h2, v);
            `CHK(v, exp_f)
        end
        // Sleep with and without the master enable
        for (int s = 1; s >= 0; s--) begin
            set_pins(8'h00, 8);
            wr_reg(4'h0, 8'h01);
            wr_reg(4'h2, 8'h00);
            wr_reg(4'h3, {6'h00, 1'b1, s[0]});
            want <= 8'h01;
            seen = 1'b0;
            for (int c = 0; c < 20 && !seen; c++) begin
                @(negedge core_clk);
                seen = wake;
            end
            `CHK(seen, s[0])
            if (s) `CHK(summary, 1'b1)
        end
        // Interrupt through status and mask
        wr_reg(4'h3, 8'h00);
        wr_reg(4'h4, 8'h03);
        wr_reg(4'h5, 8'h01);
        set_pins(8'h00, 8);
        set_pins(8'h01, 12);
        @(negedge core_clk);
        `CHK(irq, 1'b1)
        wr_reg(4'h5, 8'h00);
        // The mask write lands at this edge; irq follows one edge later
        repeat (2) @(negedge core_clk);
        `CHK(irq, 1'b0)
        wr_reg(4'h4, 8'h03);
        wr_reg(4'h5, 8'h01);
        rd_reg(4'h4, v);
        `CHK(v[0], 1'b0)
        `CHK(irq, 1'b0)
        print_verdict();
    end
endmodule : pin_edge_change_interrupt_tb_top

`default_nettype wire

//--- test/pin_source.sv
// Model of the external signals on the eight port input pins
`timescale 1ns/1ps
`default_nettype none

module pin_source (
    // Clock
    input  wire logic       core_clk_i,
    // Requested and driven levels
    input  wire logic [7:0] want_i,
    output logic      [7:0] pins_o
);
    logic [2:0] held;

    // A new level is passed only after the old one stood four cycles
    always @(posedge core_clk_i) begin
        if (want_i != pins_o && held >= 3'h3) begin
            pins_o <= want_i;
            held   <= 3'h0;
        end else if (held != 3'h7) begin
            held <= held + 3'h1;
        end
    end

    initial pins_o = 8'h00;
    initial held   = 3'h0;
endmodule : pin_source

`default_nettype wire
